// ==== bench/zphs_encoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module zphs_encoder (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] speed_cmd,
  input wire logic        dir_decrement,
  output logic     [31:0] encoder_count,
  output logic            index_pulse
);
  // one count per clock while commanded to move
  always_ff @(posedge clk or posedge rst) begin
    if (rst) encoder_count <= 32'h00000000;
    else if (speed_cmd != 16'h0000)
      encoder_count <= dir_decrement ? encoder_count - 32'h1
                                     : encoder_count + 32'h1;
  end
  // index mark once per 64 counts, only seen while turning
  assign index_pulse = (encoder_count[5:0] == 6'h20) &&
                       (speed_cmd != 16'h0000);
endmodule
`default_nettype wire

// ==== bench/zphs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module zphs_monitor #(
  parameter int PW = 32
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          power_cycle,
  input wire logic [15:0]   speed_cmd,
  input wire logic          dir_decrement,
  input wire logic          brake_cmd,
  input wire logic          homing_complete,
  input wire logic          homing_busy,
  input wire logic [PW-1:0] current_pos
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_speed_max: assert property (speed_cmd <= 16'hC350)
    else $error("speed above limit");
  a_speed_busy: assert property (speed_cmd != 16'h0000 |-> homing_busy)
    else $error("motion while not homing");
  a_start_clears: assert property ($rose(homing_busy) |-> !homing_complete)
    else $error("complete still high at start");
  a_done_stopped: assert property ($rose(homing_complete) |-> $past(brake_cmd))
    else $error("complete without standstill");
  a_pos_on_done: assert property ($changed(current_pos) |-> $rose(homing_complete))
    else $error("position loaded outside completion");
  a_dir_frozen: assert property ((!power_cycle && !psel) [*3] |=> $stable(dir_decrement))
    else $error("direction changed without power cycle");
  c_done: cover property ($rose(homing_complete));
  c_err: cover property (pslverr);
  c_brake: cover property ($rose(brake_cmd));
endmodule
bind zphs_top zphs_monitor #(.PW(PW)) i_zphs_monitor (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .power_cycle(power_cycle), .speed_cmd(speed_cmd),
  .dir_decrement(dir_decrement), .brake_cmd(brake_cmd),
  .homing_complete(homing_complete), .homing_busy(homing_busy),
  .current_pos(current_pos));
`default_nettype wire

// ==== bench/zphs_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
`define WAIT(c) while (!(c)) @(posedge clk)
module zphs_top_bench;
  import zphs_pkg::*;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, encoder_count, current_pos;
  logic        pready, pslverr, perr, index_pulse, power_cycle = 0;
  logic        start_forward = 0, start_reverse = 0;
  logic        dir_decrement, brake_cmd, homing_complete, homing_busy;
  logic [15:0] speed_cmd;
  int          n_mismatch = 0, compares = 0;
  always #50 clk = ~clk;
  zphs_top i_zphs_top (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_forward(start_forward), .start_reverse(start_reverse),
    .index_pulse(index_pulse), .power_cycle(power_cycle),
    .encoder_count(encoder_count), .speed_cmd(speed_cmd),
    .dir_decrement(dir_decrement), .brake_cmd(brake_cmd),
    .homing_complete(homing_complete), .homing_busy(homing_busy),
    .current_pos(current_pos));
  zphs_encoder i_zphs_encoder (.clk(clk), .rst(rst), .speed_cmd(speed_cmd),
    .dir_decrement(dir_decrement), .encoder_count(encoder_count),
    .index_pulse(index_pulse));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic pwr();
    @(posedge clk) power_cycle <= 1'b1;
    @(posedge clk) power_cycle <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic home(input logic dir, input logic rev);
    logic [31:0] z, d;
    @(posedge clk);
    if (rev) start_reverse <= 1'b1; else start_forward <= 1'b1;
    repeat (3) @(posedge clk);
    start_reverse <= 1'b0; start_forward <= 1'b0;
    `WAIT(homing_busy);
    `CHK(homing_complete, 1'b0)
    `CHK(speed_cmd, 16'h012C)
    `WAIT(brake_cmd);
    repeat (2) @(posedge clk);
    `CHK(speed_cmd, 16'h0000)
    apb(0, ZPHS_A_ZPOS, 32'h0, z);
    apb(1, ZPHS_A_CTRL, 32'h2, r);
    `WAIT(speed_cmd != 16'h0000);
    `CHK(speed_cmd, 16'h0014)
    apb(1, ZPHS_A_CTRL, 32'h0, r);
    `WAIT(brake_cmd);
    repeat (3) @(posedge clk);
    d = dir ? z - encoder_count : encoder_count - z;
    `CHK(d >= 32'd100 && d <= 32'd103, 1'b1)
    apb(1, ZPHS_A_CTRL, 32'h2, r);
    `WAIT(homing_complete);
    `CHK(homing_complete, 1'b1)
    `CHK(current_pos, 32'hFFFFFED4)
    apb(1, ZPHS_A_CTRL, 32'h0, r);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(0, ZPHS_A_SPEED, 32'h0, r);
    `CHK(r, {16'h0000, ZPHS_SPEED_RST})
    apb(0, ZPHS_A_CREEP, 32'h0, r);
    `CHK(r, {16'h0000, ZPHS_CREEP_RST})
    apb(0, 8'h30, 32'h0, r);
    `CHK({perr, r}, 33'h100000000)
    apb(1, ZPHS_A_MODE, 32'hA, r);
    apb(1, ZPHS_A_DIR, 32'h0, r);
    apb(1, ZPHS_A_SPEED, 32'h012C, r);
    apb(1, ZPHS_A_CREEP, 32'h0014, r);
    apb(1, ZPHS_A_OFFSET, 32'h0064, r);
    apb(1, ZPHS_A_COORD, 32'hFFFD, r);
    apb(1, ZPHS_A_SCALE, 32'h2, r);
    apb(0, ZPHS_A_STATUS, 32'h0, r);
    `CHK(r[7:4], 4'h0)
    @(posedge clk) start_forward <= 1'b1;
    repeat (3) @(posedge clk);
    start_forward <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(homing_busy, 1'b0)
    pwr();
    apb(0, ZPHS_A_STATUS, 32'h0, r);
    `CHK(r[7:4], ZPHS_MODE_INDEX)
    home(1'b0, 1'b0);
    apb(1, ZPHS_A_DIR, 32'h1, r);
    `CHK(dir_decrement, 1'b0)
    pwr();
    `CHK(dir_decrement, 1'b1)
    home(1'b1, 1'b1);
    apb(1, ZPHS_A_DIR, 32'h0, r);
    apb(1, ZPHS_A_CTRL, 32'h1, r);
    apb(0, ZPHS_A_STATUS, 32'h0, r);
    `CHK(r[3:0], 4'hD)
    `CHK(dir_decrement, 1'b0)
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== design/zphs_pkg.sv ====
package zphs_pkg;
  localparam logic [3:0]  ZPHS_MODE_INDEX    = 4'hA;
  localparam logic [3:0]  ZPHS_MODE_RST      = 4'h0;
  localparam logic [15:0] ZPHS_SPEED_RST     = 16'h00C8;
  localparam logic [15:0] ZPHS_CREEP_RST     = 16'h0014;
  localparam logic [15:0] ZPHS_OFFSET_RST    = 16'h0000;
  localparam logic [15:0] ZPHS_COORD_RST     = 16'h0000;
  localparam logic [3:0]  ZPHS_SCALE_RST     = 4'h0;
  localparam logic [15:0] ZPHS_SPEED_MAX     = 16'hC350;
  // register byte addresses
  localparam logic [7:0]  ZPHS_A_CTRL        = 8'h00;
  localparam logic [7:0]  ZPHS_A_MODE        = 8'h04;
  localparam logic [7:0]  ZPHS_A_DIR         = 8'h08;
  localparam logic [7:0]  ZPHS_A_SPEED       = 8'h0C;
  localparam logic [7:0]  ZPHS_A_CREEP       = 8'h10;
  localparam logic [7:0]  ZPHS_A_OFFSET      = 8'h14;
  localparam logic [7:0]  ZPHS_A_COORD       = 8'h18;
  localparam logic [7:0]  ZPHS_A_SCALE       = 8'h1C;
  localparam logic [7:0]  ZPHS_A_STATUS      = 8'h20;
  localparam logic [7:0]  ZPHS_A_POS         = 8'h24;
  localparam logic [7:0]  ZPHS_A_ZPOS        = 8'h28;
  // ctrl bit positions
  localparam int          ZPHS_B_APPLY       = 0;
  localparam int          ZPHS_B_STOPPED     = 1;
  typedef enum logic [2:0] {
    ZPHS_IDLE  = 3'b000,
    ZPHS_SEEK  = 3'b001,
    ZPHS_BRAKE = 3'b010,
    ZPHS_CREEP = 3'b011,
    ZPHS_SETTL = 3'b100,
    ZPHS_DONE  = 3'b101
  } zphs_state_e;
endpackage

// ==== design/zphs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module zphs_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== design/zphs_top.sv ====
// Function
// - homing starts only while the active homing mode equals code A.
// - a forward or reverse start input begins homing at homing speed.
// - homing speed is commanded only until the first index pulse.
// - on the index pulse the motor is braked to standstill.
// - after the stop the approach runs at the separate creep speed.
// - the home point sits the offset in encoder counts past the index.
// - on completion the position is loaded with the home coordinate.
// - direction 0 homes toward rising counts, 1 toward falling counts.
// - homing complete rises only after a successful sequence.
// - mode, direction, coordinate and scale apply only on power cycle or a ctrl write with the apply bit set.
// - the scale exponent scales the home coordinate into position.
`timescale 1ns/1ps
`default_nettype none
module zphs_top
  import zphs_pkg::*;
#(
  parameter int PW = 32
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          start_forward,
  input  wire logic          start_reverse,
  input  wire logic          index_pulse,
  input  wire logic          power_cycle,
  input  wire logic [PW-1:0] encoder_count,
  output logic      [15:0]   speed_cmd,
  output logic               dir_decrement,
  output logic               brake_cmd,
  output logic               homing_complete,
  output logic               homing_busy,
  output logic      [PW-1:0] current_pos
);
  import zphs_pkg::*;

  zphs_state_e state_r;
  zphs_state_e state_nxt;

  logic [2:0] pin_s;
  wire  [2:0] pin_rise;
  logic       pwr_d_r;

  zphs_sync #(.W(3)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({index_pulse, start_reverse, start_forward}),
    .q   (pin_s)
  );

  // one rising edge detector per synchronised pin
  for (genvar g = 0; g < 3; g++) begin : g_edge
    logic last_r;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        last_r <= 1'b0;
      end else begin
        last_r <= pin_s[g];
      end
    end
    assign pin_rise[g] = pin_s[g] & ~last_r;
  end

  // pending parameters, written by software
  logic [3:0]  mode_wr_r;
  logic        dir_wr_r;
  logic [15:0] coord_wr_r;
  logic [3:0]  scale_wr_r;
  logic [15:0] homing_speed_r;
  logic [15:0] creep_speed_r;
  logic [15:0] home_offset_r;
  logic        stopped_r;
  // active copies, loaded only on power cycle or ctrl apply write; then the index latch and target
  logic [3:0]  homing_type_code;
  logic        homing_dir_code;
  logic [15:0] home_coordinate_code;
  logic [3:0]  feed_scale_exponent;
  logic [PW-1:0] zpos_r;
  logic [PW-1:0] target_r;

  wire stf_rise = pin_rise[0];
  wire str_rise = pin_rise[1];
  wire idx_rise = pin_rise[2];
  wire pwr_rise = power_cycle & ~pwr_d_r;
  wire start_ev = stf_rise | str_rise;
  wire mode_ok  = (homing_type_code == ZPHS_MODE_INDEX);

  wire wr_en  = psel & penable & pwrite;
  wire rd_sel = psel & ~penable & ~pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // register selects, shared by write and read paths
  wire sel_ctrl   = hit(paddr, ZPHS_A_CTRL);
  wire sel_mode   = hit(paddr, ZPHS_A_MODE);
  wire sel_dir    = hit(paddr, ZPHS_A_DIR);
  wire sel_speed  = hit(paddr, ZPHS_A_SPEED);
  wire sel_creep  = hit(paddr, ZPHS_A_CREEP);
  wire sel_offset = hit(paddr, ZPHS_A_OFFSET);
  wire sel_coord  = hit(paddr, ZPHS_A_COORD);
  wire sel_scale  = hit(paddr, ZPHS_A_SCALE);
  wire sel_status = hit(paddr, ZPHS_A_STATUS);
  wire sel_pos    = hit(paddr, ZPHS_A_POS);
  wire sel_zpos   = hit(paddr, ZPHS_A_ZPOS);

  function automatic logic [PW-1:0] pow10(input logic [3:0] e);
    logic [PW-1:0] v;
    v = {{(PW-1){1'b0}}, 1'b1};
    for (int i = 0; i < 9; i++) begin
      if (i < int'(e)) begin
        v = PW'(v * PW'(10));
      end
    end
    pow10 = v;
  endfunction

  wire [PW-1:0] coord_ext  = PW'($signed(home_coordinate_code));
  wire [PW-1:0] coord_phys = PW'(coord_ext * pow10(feed_scale_exponent));
  wire [PW-1:0] off_ext    = {{(PW-16){1'b0}}, home_offset_r};
  wire [PW-1:0] target_dn  = PW'(encoder_count - off_ext);
  wire [PW-1:0] target_up  = PW'(encoder_count + off_ext);
  wire          at_target  = (encoder_count == target_r);
  wire          mapped     = (paddr <= ZPHS_A_ZPOS) && (paddr[1:0] == 2'b00);

  wire [15:0] spd_lim = (homing_speed_r > ZPHS_SPEED_MAX) ?
                        ZPHS_SPEED_MAX : homing_speed_r;
  wire [15:0] crp_lim = (creep_speed_r > ZPHS_SPEED_MAX) ?
                        ZPHS_SPEED_MAX : creep_speed_r;

  // next values of the motion outputs
  wire        done_ev   = (state_r == ZPHS_SETTL) &&
                          (state_nxt == ZPHS_DONE);
  wire        busy_nxt  = (state_nxt != ZPHS_IDLE) &&
                          (state_nxt != ZPHS_DONE);
  wire        brake_nxt = (state_nxt == ZPHS_BRAKE) ||
                          (state_nxt == ZPHS_SETTL);
  wire [15:0] speed_nxt = (state_nxt == ZPHS_SEEK)  ? spd_lim :
                          (state_nxt == ZPHS_CREEP) ? crp_lim : 16'h0000;

  // read data selection
  wire [31:0] rd_word =
    sel_ctrl   ? {30'h0, stopped_r, 1'b0} :
    sel_mode   ? {28'h0, mode_wr_r} :
    sel_dir    ? {31'h0, dir_wr_r} :
    sel_speed  ? {16'h0, homing_speed_r} :
    sel_creep  ? {16'h0, creep_speed_r} :
    sel_offset ? {16'h0, home_offset_r} :
    sel_coord  ? {16'h0, coord_wr_r} :
    sel_scale  ? {28'h0, scale_wr_r} :
    sel_status ? {24'h0, homing_type_code, homing_complete, state_r} :
    sel_pos    ? 32'(current_pos) :
    sel_zpos   ? 32'(zpos_r) : 32'h0;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ZPHS_IDLE: begin
        if (start_ev && mode_ok) begin
          state_nxt = ZPHS_SEEK;
        end
      end
      ZPHS_SEEK: begin
        if (idx_rise) begin
          state_nxt = ZPHS_BRAKE;
        end
      end
      ZPHS_BRAKE: begin
        if (stopped_r) begin
          state_nxt = ZPHS_CREEP;
        end
      end
      ZPHS_CREEP: begin
        if (at_target) begin
          state_nxt = ZPHS_SETTL;
        end
      end
      ZPHS_SETTL: begin
        if (stopped_r) begin
          state_nxt = ZPHS_DONE;
        end
      end
      ZPHS_DONE: begin
        if (start_ev && mode_ok) begin
          state_nxt = ZPHS_SEEK;
        end
      end
      default: state_nxt = ZPHS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ZPHS_IDLE;
      pwr_d_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pwr_d_r <= power_cycle;
    end
  end

  // pending registers, one short block each
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stopped_r <= 1'b0;
    end else if (wr_en && sel_ctrl) begin
      stopped_r <= pwdata[ZPHS_B_STOPPED];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_wr_r <= ZPHS_MODE_RST;
    end else if (wr_en && sel_mode) begin
      mode_wr_r <= pwdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_wr_r <= 1'b0;
    end else if (wr_en && sel_dir) begin
      dir_wr_r <= pwdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      homing_speed_r <= ZPHS_SPEED_RST;
    end else if (wr_en && sel_speed) begin
      homing_speed_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      creep_speed_r <= ZPHS_CREEP_RST;
    end else if (wr_en && sel_creep) begin
      creep_speed_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      home_offset_r <= ZPHS_OFFSET_RST;
    end else if (wr_en && sel_offset) begin
      home_offset_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coord_wr_r <= ZPHS_COORD_RST;
    end else if (wr_en && sel_coord) begin
      coord_wr_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scale_wr_r <= ZPHS_SCALE_RST;
    end else if (wr_en && sel_scale) begin
      scale_wr_r <= pwdata[3:0];
    end
  end

  wire apply_ev = pwr_rise |
                  (wr_en & hit(paddr, ZPHS_A_CTRL) & pwdata[ZPHS_B_APPLY]);

  // active copies follow the written values only on power cycle or ctrl apply write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      homing_type_code     <= ZPHS_MODE_RST;
      homing_dir_code      <= 1'b0;
      home_coordinate_code <= ZPHS_COORD_RST;
      feed_scale_exponent  <= ZPHS_SCALE_RST;
    end else if (apply_ev) begin
      homing_type_code     <= mode_wr_r;
      homing_dir_code      <= dir_wr_r;
      home_coordinate_code <= coord_wr_r;
      feed_scale_exponent  <= scale_wr_r;
    end
  end

  // index latch and target
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zpos_r   <= '0;
      target_r <= '0;
    end else if (state_r == ZPHS_SEEK && idx_rise) begin
      zpos_r   <= encoder_count;
      target_r <= homing_dir_code ? target_dn : target_up;
    end
  end

  // motion outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_cmd       <= '0;
      dir_decrement   <= 1'b0;
      brake_cmd       <= 1'b0;
      homing_complete <= 1'b0;
      homing_busy     <= 1'b0;
      current_pos     <= '0;
    end else begin
      dir_decrement <= homing_dir_code;
      homing_busy   <= busy_nxt;
      speed_cmd     <= speed_nxt;
      brake_cmd     <= brake_nxt;
      if (state_nxt == ZPHS_SEEK) begin
        homing_complete <= 1'b0;
      end else if (done_ev) begin
        homing_complete <= 1'b1;
        current_pos     <= coord_phys;
      end
    end
  end

  // apb read and answer, zero wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (rd_sel) begin
        prdata <= rd_word;
      end
    end
  end
endmodule
`default_nettype wire
